// ---- shared/eprom_host_defs.vh ----
// constants for the word-wide programmable rom host controller
// assumes a 40 MHz clock on mclk_i
`ifndef EPROM_HOST_DEFS_VH
`define EPROM_HOST_DEFS_VH
`define CLK_PERIOD_PS 25000
`define PULSE_TIME_US 100
`define PULSE_CYCLES ((`PULSE_TIME_US * 1000000) / `CLK_PERIOD_PS)
`define SETUP_TIME_US 2
`define SETUP_CYCLES (((`SETUP_TIME_US * 1000000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define READ_TIME_NS 250
`define READ_CYCLES (((`READ_TIME_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define DISABLE_TIME_NS 100
`define DISABLE_CYCLES (((`DISABLE_TIME_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define MAX_PULSES 4'hA
`define ID_LINE_BIT 9
`define CMD_READ 3'h0
`define CMD_PROGRAM 3'h1
`define CMD_IDENT 3'h2
`define CMD_FINAL 3'h3
`define CMD_INHIBIT 3'h4
`define BLANK_WORD 16'hFFFF
`endif

// ---- hdl/sync2.v ----
// two-flop synchroniser for one bus of pin inputs
// assumes inputs arrive from outside the mclk_i domain
`timescale 1ns/100ps
module sync2 #(
  parameter W = 16
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta_r;
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      meta_r <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// ---- hdl/eprom_host.v ----
// host controller driving a 64k x 16 programmable rom through its pins
// assumes board logic turns supply-select outputs into real voltages
// What this block does
// - data floats unless select and drive low; unread devices kept deselected
// - program: raised supplies, select low, drive high, stable data, then strobe low
// - first strobe pulse 100 us, then read back the location
// - at most ten pulse-verify rounds, then report failure
// - identifier mode: id line at high voltage, address bit 0 from id_byte_sel_i, other address lines low
// - locations may be programmed in any order, several devices in parallel
// - final check of every word with both supplies at normal level
`timescale 1ns/100ps
`include "eprom_host_defs.vh"
module eprom_host (
  input wire mclk_i,
  input wire rst_n_i,
  input wire cmd_valid_i,
  input wire [2:0] cmd_i,
  input wire [15:0] cmd_addr_i,
  input wire [15:0] cmd_data_i,
  input wire id_byte_sel_i,
  input wire [15:0] data_lines_in_i,
  output reg busy_o,
  output reg done_o,
  output reg fail_o,
  output reg [15:0] rdata_o,
  output reg [3:0] pulses_o,
  output reg [15:0] word_address_o,
  output reg [15:0] data_lines_out_o,
  output reg data_lines_oe_o,
  output reg chip_select_n_o,
  output reg output_drive_n_o,
  output reg program_strobe_n_o,
  output reg prog_supply_high_o,
  output reg main_supply_high_o,
  output reg identifier_hv_line_o
);
  localparam S_IDLE = 4'h0;
  localparam S_SETUP = 4'h1;
  localparam S_PULSE = 4'h2;
  localparam S_RECOVER = 4'h3;
  localparam S_VERIFY = 4'h4;
  localparam S_READ = 4'h5;
  localparam S_END = 4'h6;
  localparam S_FLOAT = 4'h7;
  localparam CW = 13;
  localparam integer PULSE_I = `PULSE_CYCLES;
  localparam integer SETUP_I = `SETUP_CYCLES;
  localparam integer READ_I = `READ_CYCLES + 2;
  localparam integer DIS_I = `DISABLE_CYCLES;
  localparam [CW-1:0] PULSE_N = PULSE_I[CW-1:0];
  localparam [CW-1:0] SETUP_N = SETUP_I[CW-1:0];
  localparam [CW-1:0] READ_N = READ_I[CW-1:0];
  localparam [CW-1:0] DIS_N = DIS_I[CW-1:0];

  wire [15:0] data_sync;
  reg [3:0] state_r;
  reg [CW-1:0] cnt_r;
  reg [2:0] cmd_r;
  reg [15:0] wdata_r;
  reg [3:0] tries_r;

  sync2 #(.W(16)) u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .d_i(data_lines_in_i),
    .q_o(data_sync)
  );

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_r <= S_IDLE;
      cnt_r <= {CW{1'b0}};
      cmd_r <= `CMD_READ;
      wdata_r <= `BLANK_WORD;
      tries_r <= 4'h0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      fail_o <= 1'b0;
      rdata_o <= 16'h0000;
      pulses_o <= 4'h0;
      word_address_o <= 16'h0000;
      data_lines_out_o <= 16'h0000;
      data_lines_oe_o <= 1'b0;
      chip_select_n_o <= 1'b1;
      output_drive_n_o <= 1'b1;
      program_strobe_n_o <= 1'b1;
      prog_supply_high_o <= 1'b0;
      main_supply_high_o <= 1'b0;
      identifier_hv_line_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (cmd_valid_i) begin
            busy_o <= 1'b1;
            fail_o <= 1'b0;
            cmd_r <= cmd_i;
            wdata_r <= cmd_data_i;
            tries_r <= 4'h0;
            cnt_r <= {CW{1'b0}};
            word_address_o <= cmd_addr_i;
            chip_select_n_o <= 1'b0;
            if (cmd_i == `CMD_PROGRAM) begin
              prog_supply_high_o <= 1'b1;
              main_supply_high_o <= 1'b1;
              output_drive_n_o <= 1'b1;
              data_lines_out_o <= cmd_data_i;
              data_lines_oe_o <= 1'b1;
              state_r <= S_SETUP;
            end else if (cmd_i == `CMD_INHIBIT) begin
              prog_supply_high_o <= 1'b1;
              chip_select_n_o <= 1'b1;
              state_r <= S_READ;
            end else if (cmd_i == `CMD_IDENT) begin
              word_address_o <= {15'h0000, id_byte_sel_i};
              identifier_hv_line_o <= 1'b1;
              output_drive_n_o <= 1'b0;
              state_r <= S_READ;
            end else begin
              output_drive_n_o <= 1'b0;
              state_r <= S_READ;
            end
          end
        end
        S_SETUP: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == SETUP_N - 1'b1) begin
            cnt_r <= {CW{1'b0}};
            program_strobe_n_o <= 1'b0;
            tries_r <= tries_r + 1'b1;
            state_r <= S_PULSE;
          end
        end
        S_PULSE: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == PULSE_N - 1'b1) begin
            cnt_r <= {CW{1'b0}};
            program_strobe_n_o <= 1'b1;
            state_r <= S_RECOVER;
          end
        end
        S_RECOVER: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == SETUP_N - 1'b1) begin
            cnt_r <= {CW{1'b0}};
            data_lines_oe_o <= 1'b0;
            output_drive_n_o <= 1'b0;
            state_r <= S_VERIFY;
          end
        end
        S_VERIFY: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == READ_N - 1'b1) begin
            cnt_r <= {CW{1'b0}};
            output_drive_n_o <= 1'b1;
            rdata_o <= data_sync;
            pulses_o <= tries_r;
            if (data_sync == wdata_r) begin
              state_r <= S_FLOAT;
            end else if (tries_r == `MAX_PULSES) begin
              fail_o <= 1'b1;
              state_r <= S_FLOAT;
            end else begin
              state_r <= S_END;
            end
          end
        end
        S_END: begin
          // wait for outputs to float, then drive data again
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == DIS_N) begin
            cnt_r <= {CW{1'b0}};
            data_lines_oe_o <= 1'b1;
            state_r <= S_SETUP;
          end
        end
        S_READ: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == READ_N - 1'b1) begin
            cnt_r <= {CW{1'b0}};
            if (cmd_r == `CMD_IDENT) begin
              rdata_o <= {8'h00, data_sync[7:0]};
            end else if (cmd_r == `CMD_INHIBIT) begin
              rdata_o <= 16'h0000;
            end else begin
              rdata_o <= data_sync;
              fail_o <= (cmd_r == `CMD_FINAL) && (data_sync != wdata_r);
            end
            output_drive_n_o <= 1'b1;
            state_r <= S_FLOAT;
          end
        end
        S_FLOAT: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == DIS_N) begin
            cnt_r <= {CW{1'b0}};
            chip_select_n_o <= 1'b1;
            identifier_hv_line_o <= 1'b0;
            prog_supply_high_o <= 1'b0;
            main_supply_high_o <= 1'b0;
            busy_o <= 1'b0;
            done_o <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- tb/eprom_host_assertions.sv ----
// pin sequencing checks for the rom host
// assumes binding into eprom_host
`timescale 1ns/100ps
module eprom_host_assertions (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [15:0] word_address_o,
  input wire [15:0] data_lines_out_o,
  input wire data_lines_oe_o,
  input wire chip_select_n_o,
  input wire output_drive_n_o,
  input wire program_strobe_n_o,
  input wire prog_supply_high_o,
  input wire main_supply_high_o,
  input wire identifier_hv_line_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  reg [12:0] lo_cnt_r;
  always @(posedge mclk_i)
    lo_cnt_r <= (!rst_n_i || program_strobe_n_o) ? 13'h0000 : lo_cnt_r + 13'h0001;
  chk_strobe_mode: assert property (!program_strobe_n_o |-> prog_supply_high_o &&
    main_supply_high_o && !chip_select_n_o && output_drive_n_o && data_lines_oe_o)
    else $error("strobe mode");
  chk_strobe_setup: assert property ($fell(program_strobe_n_o) |->
    $past(prog_supply_high_o, 79) && $past(data_lines_oe_o, 79)) else $error("setup");
  chk_strobe_hold: assert property (!program_strobe_n_o && !$past(program_strobe_n_o) |->
    $stable(word_address_o) && $stable(data_lines_out_o)) else $error("hold");
  chk_pulse_width: assert property ($rose(program_strobe_n_o) |-> lo_cnt_r == 13'hFA0)
    else $error("pulse width");
  chk_verify_mode: assert property (!output_drive_n_o && prog_supply_high_o |->
    program_strobe_n_o && !chip_select_n_o) else $error("verify");
  chk_read_supply: assert property (!output_drive_n_o && !prog_supply_high_o |->
    !main_supply_high_o && !chip_select_n_o) else $error("read");
  chk_bus_free: assert property (data_lines_oe_o |-> output_drive_n_o)
    else $error("contention");
  chk_ident_addr: assert property (identifier_hv_line_o |->
    word_address_o[15:1] == 15'h0000 && !prog_supply_high_o) else $error("ident");
  cover property ($fell(program_strobe_n_o));
  cover property (identifier_hv_line_o && !output_drive_n_o);
  cover property (!output_drive_n_o && !main_supply_high_o);
endmodule
bind eprom_host eprom_host_assertions eprom_host_assertions_inst (.*);

// ---- tb/rom_model.sv ----
// behavioural word-wide rom on the host pins
// assumes the host is the only other driver
`timescale 1ns/100ps
module rom_model #(
  parameter [7:0] MAKER_ID = 8'h5A, // arbitrary
  parameter [7:0] PART_ID = 8'hC3 // arbitrary
) (
  input wire [15:0] a_i,
  input wire [15:0] d_i,
  input wire d_oe_i,
  input wire cs_n_i,
  input wire oe_n_i,
  input wire pgm_n_i,
  input wire vpp_i,
  input wire vcc_i,
  input wire id_i,
  output logic [15:0] dq_o
);
  logic [15:0] mem [0:65535];
  initial for (int i = 0; i < 65536; i++) mem[i] = 16'hFFFF;
  always @(negedge pgm_n_i)
    if (!cs_n_i && oe_n_i && vpp_i && vcc_i) mem[a_i] = mem[a_i] & d_i;
  always_comb begin
    if (d_oe_i) dq_o = d_i;
    else if (cs_n_i || oe_n_i) dq_o = ~mem[a_i];
    else if (id_i && a_i[15:1] == 15'h0000 && !vpp_i && !vcc_i)
      dq_o = {~MAKER_ID, a_i[0] ? PART_ID : MAKER_ID};
    else dq_o = mem[a_i];
  end
endmodule

// ---- tb/eprom_host_test.sv ----
// self-checking bench for the rom host
// assumes rom_model on the far side of the pins
`timescale 1ns/100ps
`include "eprom_host_defs.vh"
module eprom_host_test;
  localparam [7:0] MAKER_ID = 8'h5A; // arbitrary
  localparam [7:0] PART_ID = 8'hC3; // arbitrary
  reg mclk_i = 1'b0, rst_n_i = 1'b0, cmd_valid_i = 1'b0, id_byte_sel_i = 1'b0;
  reg [2:0] cmd_i = 3'h0;
  reg [15:0] cmd_addr_i = 16'h0000, cmd_data_i = 16'h0000;
  wire [15:0] data_lines_in_i, rdata_o, word_address_o, data_lines_out_o;
  wire [3:0] pulses_o;
  wire busy_o, done_o, fail_o, data_lines_oe_o, chip_select_n_o, output_drive_n_o;
  wire program_strobe_n_o, prog_supply_high_o, main_supply_high_o, identifier_hv_line_o;
  integer err_count = 0, cmp_count = 0;
  always #12.5 mclk_i = ~mclk_i;
  eprom_host eprom_host_inst (.*);
  rom_model #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) rom_model_inst (.a_i(word_address_o),
    .d_i(data_lines_out_o), .d_oe_i(data_lines_oe_o), .cs_n_i(chip_select_n_o),
    .oe_n_i(output_drive_n_o), .pgm_n_i(program_strobe_n_o), .vpp_i(prog_supply_high_o),
    .vcc_i(main_supply_high_o), .id_i(identifier_hv_line_o), .dq_o(data_lines_in_i));
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task check(input string nm, input [15:0] seen, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task run(input [2:0] c, input [15:0] a, input [15:0] d, input s);
    integer n;
    begin
      @(posedge mclk_i);
      cmd_i <= c;
      cmd_addr_i <= a;
      cmd_data_i <= d;
      id_byte_sel_i <= s;
      cmd_valid_i <= 1'b1;
      @(posedge mclk_i);
      cmd_valid_i <= 1'b0;
      n = 0;
      while (done_o !== 1'b1 && n < 50000) begin
        @(posedge mclk_i);
        #1;
        n = n + 1;
      end
      if (n >= 50000) begin
        err_count = err_count + 1;
        tally_and_finish;
      end
      check("idle", {13'h0000, busy_o, chip_select_n_o, program_strobe_n_o}, 16'h0003);
    end
  endtask
  task program_ok;
    begin
      run(`CMD_READ, 16'h1234, 16'h0000, 1'b0);
      check("blank word", rdata_o, 16'hFFFF);
      run(`CMD_PROGRAM, 16'h1234, 16'hA5C3, 1'b0);
      check("one pulse", {11'h000, fail_o, pulses_o}, 16'h0001);
      run(`CMD_READ, 16'h1234, 16'h0000, 1'b0);
      check("read back", rdata_o, 16'hA5C3);
    end
  endtask
  task program_gives_up;
    begin
      run(`CMD_PROGRAM, 16'h1234, 16'hFF0F, 1'b0);
      check("ten pulses", {11'h000, fail_o, pulses_o}, 16'h001A);
      run(`CMD_FINAL, 16'h1234, 16'hA503, 1'b0);
      check("bits cleared only", {15'h0000, fail_o}, 16'h0000);
      run(`CMD_FINAL, 16'h1234, 16'hA5C3, 1'b0);
      check("final mismatch", {15'h0000, fail_o}, 16'h0001);
    end
  endtask
  task ident_and_inhibit;
    begin
      run(`CMD_IDENT, 16'hFFFE, 16'h0000, 1'b0);
      check("maker byte", rdata_o, {8'h00, MAKER_ID});
      run(`CMD_IDENT, 16'hFFFE, 16'h0000, 1'b1);
      check("part byte", rdata_o, {8'h00, PART_ID});
      run(`CMD_INHIBIT, 16'h0040, 16'h0000, 1'b0);
      run(`CMD_READ, 16'h0040, 16'h0000, 1'b0);
      check("inhibited word", rdata_o, 16'hFFFF);
    end
  endtask
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    program_ok;
    program_gives_up;
    ident_and_inhibit;
    tally_and_finish;
  end
endmodule
